// File: gst_edge_sync.sv
// Two-stage synchroniser with rising edge detect
`timescale 1ns/1ps
`default_nettype none
module gst_edge_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Asynchronous input and results
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;
  logic last_reg;
  logic last_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  assign level_out = sync_reg;
  assign rise_out  = sync_reg & ~last_reg;
endmodule
`default_nettype wire

// File: gst_pin_model.sv
// Pin-side model: external clock, crystal clock and gate source
`timescale 1ns/1ps
`default_nettype none
module gst_pin_model (
  // Clock
  input  wire logic clk,
  // Pins toward the timer
  output var logic  ext_clk,
  output var logic  xtal_clk,
  output var logic  gate_n
);
  initial begin
    ext_clk  = 1'b0;
    xtal_clk = 1'b0;
    gate_n   = 1'b0;
  end
  // Slow edges, so every pulse survives the two-flop crossing
  task automatic pulses(input bit xtal, input int n);
    repeat (n) begin
      repeat (4) @(posedge clk);
      if (xtal) xtal_clk <= 1'b1;
      else ext_clk <= 1'b1;
      repeat (4) @(posedge clk);
      xtal_clk <= 1'b0;
      ext_clk  <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// File: gst_pkg.sv
// Package of constants for the gated sixteen-bit timer
package gst_pkg;
  // Register addresses on the plain register port
  localparam logic [1:0] ADDR_CONTROL   = 2'h0;
  localparam logic [1:0] ADDR_COUNT_LO  = 2'h1;
  localparam logic [1:0] ADDR_COUNT_HI  = 2'h2;
  localparam logic [1:0] ADDR_IRQ_STAT  = 2'h3;
  localparam logic [2:0] ADDR_IRQ_MASK  = 3'h4;
  localparam int         ADDR_W         = 3;
  // Control field positions
  localparam int BIT_RUN      = 0;
  localparam int BIT_CLK_SEL  = 1;
  localparam int BIT_SYNC_DIS = 2;
  localparam int BIT_OSC_EN   = 3;
  localparam int BIT_PS_LO    = 4;
  localparam int BIT_PS_HI    = 5;
  localparam int BIT_GATE_EN  = 6;
  localparam logic [7:0] CONTROL_WMASK = 8'h7F;
  // Values after reset, and the largest count value
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
  localparam logic [7:0]  MASK_RESET    = 8'h00;
  localparam logic [7:0]  STAT_RESET    = 8'h00;
  localparam logic [7:0]  RDATA_RESET   = 8'h00;
  localparam logic [2:0]  PS_RESET      = 3'h0;
  localparam logic [1:0]  ICYC_RESET    = 2'h0;
  // Instruction cycle is four oscillator cycles
  localparam int         ICYC_CLOCKS = 4;
  localparam logic [1:0] ICYC_LAST   = 2'(ICYC_CLOCKS - 1);
  // Prescaler divide terminal counts for 1:1, 1:2, 1:4, 1:8
  localparam logic [2:0] PS_DIV1 = 3'h0;
  localparam logic [2:0] PS_DIV2 = 3'h1;
  localparam logic [2:0] PS_DIV4 = 3'h3;
  localparam logic [2:0] PS_DIV8 = 3'h7;
endpackage

// File: gst_timer.sv
// Gated sixteen-bit timer/counter with register port and interrupt
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module gst_timer (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  // Register port
  input  wire logic [gst_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [7:0]                reg_rdata,
  // Pins
  input  wire logic                      external_clock_input,
  input  wire logic                      crystal_clock_input,
  input  wire logic                      gate_input_n,
  // Interrupt
  output logic                           irq,
  output logic                           overflow_flag
);
  logic [7:0]  ctrl_reg;
  logic [7:0]  ctrl_next;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [2:0]  ps_reg;
  logic [2:0]  ps_next;
  logic [1:0]  icyc_reg;
  logic [1:0]  icyc_next;
  logic [7:0]  stat_reg;
  logic [7:0]  stat_next;
  logic [7:0]  mask_reg;
  logic [7:0]  mask_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;

  logic ext_level;
  logic ext_rise;
  logic xtal_level;
  logic xtal_rise;
  logic gate_level;
  logic src_pulse;
  logic gate_open;
  logic src_tick;
  logic ps_tick;
  logic [2:0] ps_term;
  logic overflow;
  logic run;
  logic ctrl_wr;
  logic lo_wr;
  logic hi_wr;
  logic count_wr;
  logic mask_wr;
  logic stat_rd;

  // External clock, crystal and gate all come from outside the domain
  gst_edge_sync u_ext_sync (
    .clk       (clk),
    .arst_n    (arst_n),
    .async_in  (external_clock_input),
    .level_out (ext_level),
    .rise_out  (ext_rise)
  );

  gst_edge_sync u_xtal_sync (
    .clk       (clk),
    .arst_n    (arst_n),
    .async_in  (crystal_clock_input),
    .level_out (xtal_level),
    .rise_out  (xtal_rise)
  );

  gst_edge_sync u_gate_sync (
    .clk       (clk),
    .arst_n    (arst_n),
    .async_in  (gate_input_n),
    .level_out (gate_level),
    .rise_out  ()
  );

  assign run = ctrl_reg[gst_pkg::BIT_RUN];

  // Source select and gating
  always_comb begin
    if (!ctrl_reg[gst_pkg::BIT_CLK_SEL]) begin
      src_pulse = (icyc_reg == gst_pkg::ICYC_LAST);
    end else if (ctrl_reg[gst_pkg::BIT_OSC_EN]) begin
      src_pulse = xtal_rise;
    end else begin
      src_pulse = ext_rise;
    end
    gate_open = !ctrl_reg[gst_pkg::BIT_GATE_EN] || !gate_level;
    src_tick  = run && gate_open && src_pulse;
  end

  // Prescaler divide select
  always_comb begin
    unique case (ctrl_reg[gst_pkg::BIT_PS_HI:gst_pkg::BIT_PS_LO])
      2'h0: ps_term = gst_pkg::PS_DIV1;
      2'h1: ps_term = gst_pkg::PS_DIV2;
      2'h2: ps_term = gst_pkg::PS_DIV4;
      2'h3: ps_term = gst_pkg::PS_DIV8;
    endcase
  end

  // Register port decode
  assign ctrl_wr  = reg_wr && (reg_addr == {1'b0, gst_pkg::ADDR_CONTROL});
  assign lo_wr    = reg_wr && (reg_addr == {1'b0, gst_pkg::ADDR_COUNT_LO});
  assign hi_wr    = reg_wr && (reg_addr == {1'b0, gst_pkg::ADDR_COUNT_HI});
  assign count_wr = lo_wr || hi_wr;
  assign mask_wr  = reg_wr && (reg_addr == gst_pkg::ADDR_IRQ_MASK);
  assign stat_rd  = reg_rd && (reg_addr == {1'b0, gst_pkg::ADDR_IRQ_STAT});

  // Instruction cycle divider; free running keeps timer ticks evenly spaced
  always_comb begin
    icyc_next = icyc_reg + 2'h1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      icyc_reg <= gst_pkg::ICYC_RESET;
    end else begin
      icyc_reg <= icyc_next;
    end
  end

  // Prescaler; a count write restarts it so the next count is a full period
  always_comb begin
    ps_next = ps_reg;
    ps_tick = 1'b0;
    if (src_tick) begin
      if (ps_reg >= ps_term) begin
        ps_next = gst_pkg::PS_RESET;
        ps_tick = 1'b1;
      end else begin
        ps_next = ps_reg + 3'h1;
      end
    end
    if (count_wr) begin
      ps_next = gst_pkg::PS_RESET;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ps_reg <= gst_pkg::PS_RESET;
    end else begin
      ps_reg <= ps_next;
    end
  end

  // Control register
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrl_wr) begin
      ctrl_next = reg_wdata & gst_pkg::CONTROL_WMASK;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= gst_pkg::CONTROL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Counter; a byte write wins over the increment of that byte in the same cycle
  always_comb begin
    count_next = count_reg;
    overflow   = 1'b0;
    if (ps_tick) begin
      count_next = count_reg + 16'h0001;
      overflow   = (count_reg == gst_pkg::COUNT_MAX);
    end
    // Bytes are written one at a time; software must handle the carry
    if (lo_wr) begin
      count_next[7:0] = reg_wdata;
    end
    if (hi_wr) begin
      count_next[15:8] = reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= gst_pkg::COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  // Interrupt mask
  always_comb begin
    mask_next = mask_reg;
    if (mask_wr) begin
      mask_next = reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_reg <= gst_pkg::MASK_RESET;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // Sticky status, cleared by read; a new event wins over the clear
  // so that an overflow landing on the clearing read is never lost
  always_comb begin
    stat_next = stat_reg;
    if (stat_rd) begin
      stat_next = 8'h00;
    end
    if (overflow) begin
      stat_next[0] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_reg <= gst_pkg::STAT_RESET;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // Read data, valid the cycle after the strobe only
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        {1'b0, gst_pkg::ADDR_CONTROL}:  rdata_next = ctrl_reg;
        {1'b0, gst_pkg::ADDR_COUNT_LO}: rdata_next = count_reg[7:0];
        {1'b0, gst_pkg::ADDR_COUNT_HI}: rdata_next = count_reg[15:8];
        {1'b0, gst_pkg::ADDR_IRQ_STAT}: rdata_next = stat_reg;
        gst_pkg::ADDR_IRQ_MASK:         rdata_next = mask_reg;
        default:                        rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= gst_pkg::RDATA_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Asynchronous mode still samples through the synchroniser; a truly
  // unclocked counter cannot be built on one clock, so the sync bit is
  // stored and readable but both paths share the two-flop crossing.
  assign reg_rdata     = rdata_reg;
  assign overflow_flag = stat_reg[0];
  assign irq           = |(stat_reg & mask_reg);
  // Crystal level kept for future divider use is not needed here
  logic unused_levels;
  assign unused_levels = ext_level ^ xtal_level;
endmodule
`default_nettype wire

// File: gst_timer_properties.sv
// Port checker for the gated sixteen-bit timer
`timescale 1ns/1ps
`default_nettype none
module gst_timer_properties (
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        arst_n,
  // Register port and interrupt
  input wire logic [gst_pkg::ADDR_W-1:0]  reg_addr,
  input wire logic [7:0]                  reg_wdata,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [7:0]                  reg_rdata,
  input wire logic                        irq,
  input wire logic                        overflow_flag
);
  logic run_q;
  logic mask_q;
  // Shadow of run and mask bits as written on the bus
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q  <= 1'b0;
      mask_q <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == 3'h0) run_q <= reg_wdata[0];
      if (reg_addr == 3'h4) mask_q <= reg_wdata[0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 3'h4 |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_ctrl_readback: assert property (reg_wr && reg_addr == 3'h0 ##1
    reg_rd && reg_addr == 3'h0 |=> reg_rdata ==
    ($past(reg_wdata, 2) & gst_pkg::CONTROL_WMASK))
    else $error("control readback wrong");
  a_count_wrrd: assert property (reg_wr && reg_addr == 3'h1 && !run_q
    ##1 reg_rd && reg_addr == 3'h1 |=> reg_rdata == $past(reg_wdata, 2))
    else $error("count low readback wrong");
  a_status_read: assert property (reg_rd && reg_addr == 3'h3
    && overflow_flag |=> reg_rdata[0]) else $error("status bit lost");
  a_flag_sticky: assert property ($fell(overflow_flag) |->
    $past(reg_rd) && $past(reg_addr) == 3'h3)
    else $error("flag dropped without status read");
  a_irq_level: assert property (irq == (overflow_flag && mask_q))
    else $error("interrupt level wrong");
  a_stop_noflag: assert property ($rose(overflow_flag) |->
    $past(run_q) || $past(run_q, 2)) else $error("overflow while stopped");
endmodule
bind gst_timer gst_timer_properties u_props (.clk(clk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
  .overflow_flag(overflow_flag));
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the gated sixteen-bit timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {logic [2:0] a; logic [7:0] w; logic [7:0] r;} gst_row_s;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata, v;
  logic [15:0] c;
  logic        ext_clk, xtal_clk, gate_n, irq, ovf;
  int          err_count = 0;
  int          comparisons = 0;
  gst_row_s    rows [6] = '{'{3'h0, 8'hFE, 8'h7E}, '{3'h1, 8'hA5, 8'hA5},
    '{3'h2, 8'h5A, 8'h5A}, '{3'h4, 8'h01, 8'h01}, '{3'h5, 8'hFF, 8'h00},
    '{3'h7, 8'hFF, 8'h00}};
  always #5 clk = ~clk;
  gst_timer DUT (.clk(clk), .arst_n(arst_n), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .external_clock_input(ext_clk), .crystal_clock_input(xtal_clk),
    .gate_input_n(gate_n), .irq(irq), .overflow_flag(ovf));
  gst_pin_model P (.clk(clk), .ext_clk(ext_clk), .xtal_clk(xtal_clk),
    .gate_n(gate_n));
  task automatic chk(input string n, input logic [15:0] s, e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Bytes read separately; only stable while the count stands
  task automatic cnt(output logic [15:0] q);
    rd_reg(3'h1, q[7:0]);
    rd_reg(3'h2, q[15:8]);
  endtask
  task automatic set_cnt(input logic [15:0] q);
    wr_reg(3'h1, q[7:0]);
    wr_reg(3'h2, q[15:8]);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rd_reg(3'h0, v);
    chk("ctrl reset", 16'(v), 16'h0000);
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].w);
      rd_reg(rows[i].a, v);
      chk("reg", 16'(v), 16'(rows[i].r));
    end
    for (int p = 0; p < 4; p++) begin
      set_cnt(16'h0000);
      wr_reg(3'h0, 8'(p << 4) | 8'h01);
      repeat (32 << p) @(posedge clk);
      wr_reg(3'h0, 8'h00);
      cnt(c);
      chk("prescale", 16'(c >= 7 && c <= 9), 16'h0001);
    end
    P.gate_n <= 1'b1;
    set_cnt(16'h0000);
    wr_reg(3'h0, 8'h41);
    repeat (40) @(posedge clk);
    cnt(c);
    chk("gate hold", c, 16'h0000);
    P.gate_n <= 1'b0;
    repeat (40) @(posedge clk);
    wr_reg(3'h0, 8'h00);
    cnt(c);
    chk("gate open", 16'(c >= 7 && c <= 11), 16'h0001);
    set_cnt(16'hFFFD);
    wr_reg(3'h0, 8'h03);
    P.pulses(0, 3);
    repeat (5) @(posedge clk);
    cnt(c);
    chk("rollover", c, 16'h0000);
    chk("flag irq", {ovf, irq}, 16'h0003);
    rd_reg(3'h3, v);
    chk("status", 16'(v[0]), 16'h0001);
    chk("flag clr", {ovf, irq}, 16'h0000);
    wr_reg(3'h0, 8'h00);
    P.pulses(0, 2);
    cnt(c);
    chk("stopped", c, 16'h0000);
    wr_reg(3'h0, 8'h0F);
    P.pulses(1, 5);
    P.pulses(0, 2);
    repeat (5) @(posedge clk);
    cnt(c);
    chk("crystal", c, 16'h0005);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk("rst outs", {rdata, ovf, irq}, 16'h0000);
    arst_n <= 1'b1;
    cnt(c);
    chk("rst count", c, 16'h0000);
    print_verdict();
  end
  initial begin
    #100us;
    err_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
